// ---- rtl/seq_core.sv ----
// Programmable logic sequencer core: AND, complement and J-K OR arrays,
// two register banks, control pin functions, APB configuration slave.
// Assumes board pins arrive asynchronously; APB runs on clk.
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/100ps

// Notes on behaviour
// R1 - Reset presets every state and output register to one.
// R2 - Unprogrammed cells all conduct: terms inactive, options low.
// R3 - A term with any intact link pair is always inactive.
// R4 - Software must not let an active term feed itself via complement.
// R5 - Complement logic passes the AND array twice.
// R6 - With second clock chosen, software unlinks input 5 from the array.
// R7 - Control pin acts as power down, init, output enable or input.
// R8 - In power-down mode the shared input 16 is masked from the arrays.
// R9 - Internal term control of a bank overrides the pin for that function.
// R10 - Registers 0-3 form bank A, 4-7 bank B, each with own control.
// R11 - Rising init forces the bank to its preset or reset value.
// R12 - Clocks during init or power down are ignored.
// R13 - Output enable high turns the bank's outputs off.
// R14 - Power down turns outputs off; first clock after release is valid.
// R15 - Diagnostic mode loads inputs into registers on rising clock.
// R16 - Software keeps inputs 10-12 off the init and enable terms.
// R17 - Powered down, registers hold and outputs stay off; the core still lets an internal init term preset or reset them.
// R18 - Registers update on their clock from J-K terms of the OR array.
// R19 - An unprogrammed init option leaves the bank unchanged.
module seq_core
   import seq_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire seq_pkg::apb_req_t apb_req,
   output seq_pkg::apb_rsp_t apb_rsp,
   input wire seq_pkg::pin_in_t pins,
   output logic [seq_pkg::N_REG-1:0] seq_out,
   output logic [seq_pkg::N_REG-1:0] seq_out_en
);

   import seq_pkg::*;

   typedef struct packed
   {
      ctrl_t ctrl;
      logic [6:0] term_sel;
      logic [N_TERM-1:0][ROW_W-1:0] and_cfg;
      logic [N_OR_TERM-1:0][31:0] or_cfg;
      logic [N_REG-1:0] p;
      logic [N_REG-1:0] f;
      logic [N_REG-1:0] out_en;
      logic [SYNC_W-1:0] s1;
      logic [SYNC_W-1:0] s2;
      logic [1:0] clk_q;
      logic [1:0] init_q;
      apb_rsp_t rsp;
   } state_t;

   state_t st;
   state_t next_st;

   logic [N_IN-1:0] in_v;
   logic clk1_s;
   logic clk2_s;
   logic pin_s;
   logic power_down_request;
   logic comp;
   logic [N_TERM-1:0] hit1;
   logic [N_TERM-1:0] hit;
   logic [N_TERM-1:0] comp_link;
   logic [1:0] init_lv;
   logic [1:0] oe_off;
   logic init_term_bank_a;
   logic init_term_bank_b;
   logic enable_term_bank_a;
   logic enable_term_bank_b;
   logic [1:0] rise;
   logic [1:0] bank_edge;
   logic [1:0] init_rise;
   logic [15:0] jv;
   logic [15:0] kv;
   logic [6:0] sel;
   logic sel_ok;
   logic sel_or_ok;
   logic addr_ok;
   logic [31:0] rdata;

   assign clk1_s = st.s2[N_IN];
   assign clk2_s = st.s2[N_IN+1];
   assign pin_s = st.s2[N_IN+2];
   assign power_down_request =
      (st.ctrl.pin_func == PIN_POWER_DOWN) && pin_s; // R7

   // Shared input never reaches the arrays while the pin is power down
   always_comb
   begin
      in_v = st.s2[N_IN-1:0];
      if (st.ctrl.pin_func == PIN_POWER_DOWN)
         in_v[PD_SHARED_INPUT] = 1'b0; // R8
   end

   // First pass ignores the complement literal, second pass uses it
   genvar g;
   generate
      for (g = 0; g < N_TERM; g++)
      begin : g_term
         logic [2*N_LIT-1:0] link1;
         always_comb
         begin
            link1 = st.and_cfg[g][2*N_LIT-1:0];
            link1[2*LIT_COMP+1 -: 2] = 2'h0;
         end
         pterm_gate #(.N(N_LIT)) u_pass1 (
            .link(link1),
            .lit({1'b0, st.p, in_v}),
            .hit(hit1[g])
         );
         pterm_gate #(.N(N_LIT)) u_pass2 (
            .link(st.and_cfg[g][2*N_LIT-1:0]),
            .lit({comp, st.p, in_v}),
            .hit(hit[g])
         );
         assign comp_link[g] = st.and_cfg[g][LINK_COMP_USE];
      end
   endgenerate

   // Terms feeding the complement see only first-pass terms, so no loop
   assign comp = ~|(hit1 & comp_link); // R5

   assign init_term_bank_a = hit[TERM_INIT_A];
   assign init_term_bank_b = hit[TERM_INIT_B];
   assign enable_term_bank_a = hit[TERM_OE_A];
   assign enable_term_bank_b = hit[TERM_OE_B];

   always_comb
   begin
      init_lv[0] = st.ctrl.int_init_a ? init_term_bank_a :
         ((st.ctrl.pin_func == PIN_INIT) && pin_s); // R9
      init_lv[1] = st.ctrl.int_init_b ? init_term_bank_b :
         ((st.ctrl.pin_func == PIN_INIT) && pin_s); // R9
      oe_off[0] = st.ctrl.int_oe_a ? enable_term_bank_a :
         ((st.ctrl.pin_func == PIN_OE) && pin_s); // R9
      oe_off[1] = st.ctrl.int_oe_b ? enable_term_bank_b :
         ((st.ctrl.pin_func == PIN_OE) && pin_s); // R9
   end

   function automatic logic jk_next(
      input logic q,
      input logic j,
      input logic k
   );
      unique case ({j, k})
         2'b00: jk_next = q;
         2'b10: jk_next = 1'b1;
         2'b01: jk_next = 1'b0;
         2'b11: jk_next = ~q;
      endcase
   endfunction

   function automatic logic [31:0] read_word(
      input state_t s,
      input logic [11:0] addr,
      input logic ok,
      input logic or_ok,
      input logic [1:0] il,
      input logic pd
   );
      read_word = 32'h0000_0000;
      unique case (addr)
         OFF_CTRL: read_word[CTRL_W-1:0] = s.ctrl;
         OFF_TERM_SEL: read_word[6:0] = s.term_sel;
         OFF_AND_LO:
            if (ok)
               read_word = s.and_cfg[s.term_sel][31:0];
         OFF_AND_HI:
            if (ok)
               read_word[ROW_W-33:0] = s.and_cfg[s.term_sel][ROW_W-1:32];
         OFF_OR_JK:
            if (or_ok)
               read_word = s.or_cfg[s.term_sel[5:0]];
         OFF_STATUS: read_word[10:0] = {il, pd, s.out_en};
         OFF_REGS: read_word[15:0] = {s.f, s.p};
         default: read_word = 32'h0000_0000;
      endcase
   endfunction

   always_comb
   begin
      next_st = st;
      next_st.s1 = pins;
      next_st.s2 = st.s1;
      next_st.clk_q = {clk2_s, clk1_s};
      next_st.init_q = init_lv;
      next_st.rsp.pready = 1'b0;
      next_st.rsp.pslverr = 1'b0;
      // Read data shows only in the answer cycle
      next_st.rsp.prdata = 32'h0000_0000;

      rise = {clk2_s & ~st.clk_q[1], clk1_s & ~st.clk_q[0]};
      bank_edge[0] = rise[0];
      bank_edge[1] = st.ctrl.clock_select_option ? rise[1] : rise[0]; // R10
      init_rise = init_lv & ~st.init_q;

      jv = 16'h0000;
      kv = 16'h0000;
      for (int t = 0; t < N_OR_TERM; t++)
      begin
         if (hit[t])
         begin
            jv = jv | st.or_cfg[t][15:0];
            kv = kv | st.or_cfg[t][31:16];
         end
      end

      for (int r = 0; r < N_REG; r++)
      begin
         if (init_rise[r / BANK_SIZE])
         begin
            unique case (r < BANK_SIZE ? st.ctrl.init_opt_a :
               st.ctrl.init_opt_b)
               INIT_PRESET:
               begin
                  next_st.p[r] = 1'b1; // R11
                  next_st.f[r] = 1'b1;
               end
               INIT_RESET:
               begin
                  next_st.p[r] = 1'b0; // R11
                  next_st.f[r] = 1'b0;
               end
               default:
               begin
                  next_st.p[r] = st.p[r]; // R19
                  next_st.f[r] = st.f[r];
               end
            endcase
         end
         else if (bank_edge[r / BANK_SIZE] && !power_down_request &&
            !init_lv[r / BANK_SIZE] && !st.init_q[r / BANK_SIZE]) // R12
         begin
            if (st.ctrl.diag)
            begin
               next_st.p[r] = in_v[r]; // R15
               next_st.f[r] = in_v[DIAG_OUT_BASE + r];
            end
            else
            begin
               next_st.p[r] = jk_next(st.p[r], jv[r], kv[r]); // R18
               next_st.f[r] = jk_next(st.f[r], jv[N_REG + r],
                  kv[N_REG + r]);
            end
         end
         // Power down drops every enable; the bank's own enable otherwise
         next_st.out_en[r] =
            !power_down_request && !oe_off[r / BANK_SIZE]; // R13 R14 R17
      end

      // Row access goes through the term select register
      sel = st.term_sel;
      sel_ok = (sel < 7'(N_TERM));
      sel_or_ok = (sel < 7'(N_OR_TERM));
      addr_ok = (apb_req.paddr == OFF_CTRL) ||
         (apb_req.paddr == OFF_TERM_SEL) ||
         (apb_req.paddr == OFF_AND_LO) ||
         (apb_req.paddr == OFF_AND_HI) ||
         (apb_req.paddr == OFF_OR_JK) ||
         (apb_req.paddr == OFF_STATUS) ||
         (apb_req.paddr == OFF_REGS);
      rdata = read_word(st, apb_req.paddr, sel_ok, sel_or_ok, init_lv,
         power_down_request);

      // One wait state: answer is prepared, the write lands on completion
      if (apb_req.psel && apb_req.penable && !st.rsp.pready)
      begin
         next_st.rsp.pready = 1'b1;
         next_st.rsp.pslverr = !addr_ok;
         next_st.rsp.prdata = (addr_ok && !apb_req.pwrite) ? rdata :
            32'h0000_0000;
      end
      if (apb_req.psel && apb_req.penable && st.rsp.pready &&
         apb_req.pwrite && addr_ok)
      begin
         unique case (apb_req.paddr)
            OFF_CTRL:
               next_st.ctrl = ctrl_t'(apb_req.pwdata[CTRL_W-1:0]); // R7
            OFF_TERM_SEL:
               next_st.term_sel = apb_req.pwdata[6:0];
            OFF_AND_LO:
               if (sel_ok)
                  next_st.and_cfg[sel][31:0] = apb_req.pwdata;
            OFF_AND_HI:
               if (sel_ok)
                  next_st.and_cfg[sel][ROW_W-1:32] =
                     apb_req.pwdata[ROW_W-33:0];
            OFF_OR_JK:
               if (sel_or_ok)
                  next_st.or_cfg[sel[5:0]] = apb_req.pwdata;
            default:
               next_st.ctrl = st.ctrl;
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st <= '0;
         st.ctrl <= CTRL_RESET; // R2
         st.and_cfg <= {N_TERM{AND_ROW_RESET}}; // R2
         st.or_cfg <= {N_OR_TERM{OR_ROW_RESET}};
         st.p <= REG_PRESET; // R1
         st.f <= REG_PRESET; // R1
         st.out_en <= OE_RESET;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign apb_rsp = st.rsp;
   assign seq_out = st.f;
   assign seq_out_en = st.out_en;

endmodule

// ---- rtl/seq_pkg.sv ----
// Constants, register map and carrier types of the logic sequencer core.
// Assumes an APB master on the same clock and unsynchronised board pins.
package seq_pkg;

   localparam int unsigned N_IN = 17;
   localparam int unsigned N_REG = 8;
   localparam int unsigned N_TERM = 68;
   localparam int unsigned N_OR_TERM = 64;
   localparam int unsigned N_LIT = N_IN + N_REG + 1;
   localparam int unsigned ROW_W = 2 * N_LIT + 1;
   localparam int unsigned BANK_SIZE = 4;

   // Special product terms, outside the OR array
   localparam int unsigned TERM_INIT_A = 64;
   localparam int unsigned TERM_INIT_B = 65;
   localparam int unsigned TERM_OE_A = 66;
   localparam int unsigned TERM_OE_B = 67;

   // Literal and link positions inside one AND row
   localparam int unsigned LIT_STATE = N_IN;
   localparam int unsigned LIT_COMP = N_IN + N_REG;
   localparam int unsigned LINK_COMP_USE = 2 * N_LIT;
   localparam int unsigned PD_SHARED_INPUT = 16;
   localparam int unsigned DIAG_OUT_BASE = 8;

   // Byte offsets on APB
   localparam logic [11:0] OFF_CTRL = 12'h000;
   localparam logic [11:0] OFF_TERM_SEL = 12'h004;
   localparam logic [11:0] OFF_AND_LO = 12'h008;
   localparam logic [11:0] OFF_AND_HI = 12'h00c;
   localparam logic [11:0] OFF_OR_JK = 12'h010;
   localparam logic [11:0] OFF_STATUS = 12'h014;
   localparam logic [11:0] OFF_REGS = 12'h018;

   // Every cell intact: all terms inactive, no complement link
   localparam logic [ROW_W-1:0] AND_ROW_RESET = 53'h0f_ffff_ffff_ffff;
   localparam logic [31:0] OR_ROW_RESET = 32'h0000_0000;
   localparam logic [N_REG-1:0] REG_PRESET = 8'hff;
   localparam logic [N_REG-1:0] OE_RESET = 8'hff;

   typedef enum logic [1:0]
   {
      PIN_INPUT = 2'h0,
      PIN_POWER_DOWN = 2'h1,
      PIN_OE = 2'h2,
      PIN_INIT = 2'h3
   } pin_func_t;

   typedef enum logic [1:0]
   {
      INIT_NONE = 2'h0,
      INIT_PRESET = 2'h1,
      INIT_RESET = 2'h2,
      INIT_UNDEF = 2'h3
   } init_opt_t;

   typedef struct packed
   {
      logic int_oe_b;
      logic int_oe_a;
      logic int_init_b;
      logic int_init_a;
      init_opt_t init_opt_b;
      init_opt_t init_opt_a;
      logic diag;
      logic clock_select_option;
      pin_func_t pin_func;
   } ctrl_t;

   localparam int unsigned CTRL_W = $bits(ctrl_t);
   localparam ctrl_t CTRL_RESET = ctrl_t'(12'h000);

   typedef struct packed
   {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed
   {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } apb_rsp_t;

   typedef struct packed
   {
      logic ctl_pin;
      logic clk2;
      logic clk1;
      logic [N_IN-1:0] din;
   } pin_in_t;

   localparam int unsigned SYNC_W = $bits(pin_in_t);

endpackage

// ---- rtl/pterm_gate.sv ----
// One AND-array product term over true/complement link pairs.
// Assumes link bit 2i connects the true literal, bit 2i+1 its complement.
`timescale 1ns/100ps

module pterm_gate #(
   parameter int unsigned N = 26
)
(
   input wire logic [2*N-1:0] link,
   input wire logic [N-1:0] lit,
   output logic hit
);

   always_comb
   begin
      hit = 1'b1;
      for (int i = 0; i < N; i++)
      begin
         if (link[2*i] && link[2*i+1])
            hit = 1'b0; // R3
         else if (link[2*i] && !lit[i])
            hit = 1'b0;
         else if (link[2*i+1] && lit[i])
            hit = 1'b0;
      end
   end

endmodule

// ---- tb/seq_core_sva.sv ----
// Checker of the sequencer core: bus answer timing and pin control.
// Sees only the core's ports; bound to every seq_core instance.
`timescale 1ns/100ps
module seq_core_sva
   import seq_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire seq_pkg::apb_req_t apb_req,
   input wire seq_pkg::apb_rsp_t apb_rsp,
   input wire seq_pkg::pin_in_t pins,
   input wire logic [seq_pkg::N_REG-1:0] seq_out,
   input wire logic [seq_pkg::N_REG-1:0] seq_out_en
);
   ctrl_t ctrl;
   logic pd_mode;
   logic oe_mode;
   logic quiet;
   // Shadow of the control word, taken only at the completing edge
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         ctrl <= CTRL_RESET;
      else if (apb_rsp.pready && !apb_rsp.pslverr && apb_req.pwrite
               && apb_req.paddr == OFF_CTRL)
         ctrl <= ctrl_t'(apb_req.pwdata[CTRL_W-1:0]);
   end
   assign pd_mode = ctrl.pin_func == PIN_POWER_DOWN;
   assign oe_mode = ctrl.pin_func == PIN_OE;
   assign quiet = (pd_mode || oe_mode) && !ctrl.int_oe_a
                  && !ctrl.int_oe_b && !pins.ctl_pin;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!nrst);
   // Margin of six samples covers the pin synchroniser and output flop
   sequence pd_held;
      (pd_mode && pins.ctl_pin) [*6];
   endsequence
   sequence oe_held;
      (oe_mode && !ctrl.int_oe_a && !ctrl.int_oe_b && pins.ctl_pin) [*6];
   endsequence
   a_reset_preset: assert property ($rose(nrst) |-> seq_out == REG_PRESET)
      else $error("outputs not preset after reset");
   a_ready_delay: assert property (apb_req.psel && $rose(apb_req.penable) |=> apb_rsp.pready)
      else $error("answer not in second access cycle");
   a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
      else $error("ready longer than one cycle");
   a_error_quiet: assert property (apb_rsp.pslverr |->
         apb_rsp.pready && apb_rsp.prdata == 32'h0)
      else $error("error answer malformed");
   a_data_idle: assert property (!apb_rsp.pready |-> apb_rsp.prdata == 32'h0)
      else $error("read data outside answer");
   a_pd_off: assert property (pd_held |-> seq_out_en == 8'h00)
      else $error("outputs on while powered down");
   a_pd_hold: assert property (pd_held ##1 (pd_mode && pins.ctl_pin)
         |-> $stable(seq_out))
      else $error("registers changed while powered down");
   a_oe_off: assert property (oe_held |-> seq_out_en == 8'h00)
      else $error("outputs on with enable pin high");
   a_en_back: assert property (quiet [*6] |-> seq_out_en == 8'hff)
      else $error("outputs not restored");
endmodule
bind seq_core seq_core_sva i_sva (.clk(clk), .nrst(nrst),
   .apb_req(apb_req), .apb_rsp(apb_rsp), .pins(pins),
   .seq_out(seq_out), .seq_out_en(seq_out_en));

// ---- tb/board_model.sv ----
// Board-side model: drives sequencer inputs, clocks and control pin.
// Assumes the bench calls its tasks; clk is the system clock.
`timescale 1ns/100ps
module board_model
   import seq_pkg::*;
(
   input wire logic clk,
   output seq_pkg::pin_in_t pins
);
   // Second clock idles low; bench keeps input 5 unlinked while it runs
   initial pins = '0;
   task automatic set_din(input logic [N_IN-1:0] v);
      @(posedge clk);
      pins.din <= v;
   endtask
   task automatic set_ctl(input logic v);
      @(posedge clk);
      pins.ctl_pin <= v;
      repeat (8) @(posedge clk);
   endtask
   // Slow board clock, several system cycles high and low
   task automatic pulse;
      @(posedge clk);
      pins.clk1 <= 1'b1;
      repeat (4) @(posedge clk);
      pins.clk1 <= 1'b0;
      repeat (5) @(posedge clk);
   endtask
   task automatic pulse_second;
      @(posedge clk);
      pins.clk2 <= 1'b1;
      repeat (4) @(posedge clk);
      pins.clk2 <= 1'b0;
      repeat (5) @(posedge clk);
   endtask
endmodule

// ---- tb/seq_core_test.sv ----
// Self-checking bench of the sequencer core over APB and board pins.
// Assumes the board model drives the pins and the checker is bound.
`timescale 1ns/100ps
module seq_core_test;
   import seq_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   apb_req_t req = '0;
   apb_rsp_t rsp;
   pin_in_t pins;
   logic [N_REG-1:0] f_out;
   logic [N_REG-1:0] f_en;
   int bad_count = 0;
   int checked = 0;
   int cycles = 0;
   always #12.5 clk = ~clk;
   seq_core i_dut (.clk(clk), .nrst(nrst), .apb_req(req), .apb_rsp(rsp),
      .pins(pins), .seq_out(f_out), .seq_out_en(f_en));
   board_model i_board (.clk(clk), .pins(pins));
   task automatic test_done;
      if (bad_count == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
         bad_count++;
      end
   endtask
   task automatic bus(input logic wr, input logic [11:0] a,
         input logic [31:0] d, output logic [31:0] rd, output logic err);
      @(posedge clk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge clk);
      req.penable <= 1'b1;
      // Only the bench timeout ends a wait for the answer
      do
         @(posedge clk);
      while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic err;
      bus(1'b1, a, d, rd, err);
      chk("write error", 32'h0, {31'h0, err});
   endtask
   task automatic rdchk(input string what, input logic [11:0] a,
                        input logic [31:0] exp);
      logic [31:0] rd;
      logic err;
      bus(1'b0, a, 32'h0, rd, err);
      chk(what, exp, rd);
   endtask
   task automatic t_reset;
      logic [31:0] rd;
      logic err;
      chk("seq_out", 32'hff, {24'h0, f_out});
      chk("seq_out_en", 32'hff, {24'h0, f_en});
      rdchk("ctrl", OFF_CTRL, 32'h0);
      rdchk("regs", OFF_REGS, 32'h0000_ffff);
      rdchk("and_lo", OFF_AND_LO, 32'hffff_ffff);
      bus(1'b0, 12'h01c, 32'h0, rd, err);
      chk("unmapped error", 32'h1, {31'h0, err});
   endtask
   task automatic t_jk;
      logic [31:0] jk [4] = '{32'h0100_0000, 32'h0200_0200,
                              32'h0000_0100, 32'h0};
      logic [7:0] want [4] = '{8'hfe, 8'hfc, 8'hfd, 8'hfd};
      wr(OFF_OR_JK, jk[0]);
      i_board.pulse();
      chk("seq_out", 32'hff, {24'h0, f_out});
      wr(OFF_AND_LO, 32'h0000_0003);
      wr(OFF_AND_HI, 32'h0);
      i_board.pulse();
      chk("seq_out", 32'hff, {24'h0, f_out});
      // Don't care links only, none into the complement array
      wr(OFF_AND_LO, 32'h0);
      for (int i = 0; i < 4; i++)
      begin
         wr(OFF_OR_JK, jk[i]);
         i_board.pulse();
         chk("seq_out", {24'h0, want[i]}, {24'h0, f_out});
      end
   endtask
   task automatic t_diag_pd;
      wr(OFF_CTRL, 32'h8);
      i_board.set_din(17'h0_5a3c);
      i_board.pulse();
      chk("seq_out", 32'h5a, {24'h0, f_out});
      rdchk("regs", OFF_REGS, 32'h0000_5a3c);
      wr(OFF_CTRL, 32'h1);
      wr(OFF_OR_JK, 32'hff00_0000);
      i_board.set_ctl(1'b1);
      chk("seq_out_en", 32'h0, {24'h0, f_en});
      rdchk("status", OFF_STATUS, 32'h100);
      i_board.pulse();
      chk("seq_out", 32'h5a, {24'h0, f_out});
      i_board.set_ctl(1'b0);
      chk("seq_out_en", 32'hff, {24'h0, f_en});
      i_board.pulse();
      chk("seq_out", 32'h0, {24'h0, f_out});
   endtask
   task automatic t_init_oe;
      logic [31:0] mode [3] = '{32'h13, 32'h63, 32'hf3};
      logic [7:0] want [3] = '{8'h0f, 8'hf0, 8'hf0};
      for (int i = 0; i < 3; i++)
      begin
         wr(OFF_CTRL, mode[i]);
         i_board.set_ctl(1'b1);
         i_board.set_ctl(1'b0);
         chk("seq_out", {24'h0, want[i]}, {24'h0, f_out});
      end
      wr(OFF_CTRL, 32'h2);
      i_board.set_ctl(1'b1);
      chk("seq_out_en", 32'h0, {24'h0, f_en});
      wr(OFF_CTRL, 32'h402);
      // New control word reaches the enable flops one edge later
      repeat (2) @(posedge clk);
      chk("seq_out_en", 32'h0f, {24'h0, f_en});
      i_board.set_ctl(1'b0);
   endtask
   task automatic t_options;
      wr(OFF_CTRL, 32'h4);
      wr(OFF_OR_JK, 32'hff00_ff00);
      i_board.pulse();
      chk("seq_out", 32'hff, {24'h0, f_out});
      i_board.pulse_second();
      chk("seq_out", 32'h0f, {24'h0, f_out});
      // Term 0 now needs the shared input high
      wr(OFF_AND_HI, 32'h0000_0001);
      wr(OFF_OR_JK, 32'hff00_0000);
      wr(OFF_CTRL, 32'h1);
      i_board.set_din(17'h1_ffff);
      i_board.pulse();
      chk("seq_out", 32'h0f, {24'h0, f_out});
      wr(OFF_CTRL, 32'h0);
      i_board.pulse();
      chk("seq_out", 32'h00, {24'h0, f_out});
      // Term 0 reads the complement, term 1 feeds it
      wr(OFF_AND_HI, 32'h0004_0000);
      wr(OFF_OR_JK, 32'h0000_ff00);
      wr(OFF_TERM_SEL, 32'h1);
      wr(OFF_AND_LO, 32'h0);
      wr(OFF_AND_HI, 32'h0010_0000);
      i_board.pulse();
      chk("seq_out", 32'h00, {24'h0, f_out});
      wr(OFF_AND_LO, 32'h3);
      i_board.pulse();
      chk("seq_out", 32'hff, {24'h0, f_out});
   endtask
   initial
   begin
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_jk();
      t_diag_pd();
      t_init_oe();
      t_options();
      test_done();
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         bad_count++;
         test_done();
      end
   end
endmodule
